// >>> hdl/buck4_cfg_pkg.sv
// Contract
// - Wake slot bits 15:13 reset 000; 000 off, 001-101 slots 1-5, 110/111 enable inputs.
// - Wake mode bits 9:8 reset 01: forced, auto, linear, hysteretic.
// - Wake voltage code bits 6:0 resets zero; 0.85V, 25mV steps, 66h up saturate.
// - Boot configuration loads only wake voltage bits 6:2, giving 100mV resolution.
// - Doze slot: 000 transition slot 5, 001-101 disable slots 5-1, 110/111 slots 3/1.
// - Under enable input control, doze codes 001-101 mean sleep entry slot, not disable.
// - Doze mode bits 9:8 reset 11: forced, pulse skipping, linear, hysteretic.
// - Doze voltage bits 6:0 reset zero, same scale as the wake code.
// - Pin control voltage choice bit 10: 0 wake code, 1 doze code.
// - Pin control source bits 12:11: off, input 1, input 2, either input.
package buck4_cfg_pkg;
  localparam logic [29:0] IDX_PIN_CTRL   = 30'h4065;
  localparam logic [29:0] IDX_WAKE_CFG   = 30'h4066;
  localparam logic [29:0] IDX_DOZE_CTRL  = 30'h4067;
  localparam int          SLOT_LSB       = 13;
  localparam int          SRC_LSB        = 11;
  localparam int          CHOICE_BIT     = 10;
  localparam int          MODE_LSB       = 8;
  localparam int          VHI_LSB        = 2;
  localparam logic [2:0]  SLOT_RESET     = 3'h0;
  localparam logic [1:0]  WAKE_MODE_RST  = 2'h1;
  localparam logic [1:0]  DOZE_MODE_RST  = 2'h3;
  localparam logic [6:0]  VCODE_RESET    = 7'h00;
  localparam logic [1:0]  SRC_RESET      = 2'h0;
  localparam logic [2:0]  SLOT_OFF       = 3'h0;
  localparam logic [2:0]  SLOT_LAST      = 3'h5;
  localparam logic [2:0]  SLOT_HW1       = 3'h6;
  localparam logic [2:0]  SLOT_HW2       = 3'h7;
  localparam logic [6:0]  VCODE_SAT      = 7'h66;
  localparam int          VBASE_MV       = 850;
  localparam int          VSTEP_MV       = 25;
  localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;
  localparam logic [2:0]  HSIZE_WORD     = 3'h2;
  typedef enum logic [1:0] {mode_forced, mode_auto, mode_linear, mode_hysteretic} buck_mode_t;
endpackage : buck4_cfg_pkg

// >>> hdl/buck4_on_sleep_config_regs.sv
// Decided for this implementation: the AHB-Lite slave port.
`timescale 1ns/1ps
module buck4_on_sleep_config_regs
  import buck4_cfg_pkg::*;
#(
  parameter int ADDR_W = 32
) (
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              hsel,
  input  wire logic [ADDR_W-1:0] haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  input  wire logic              boot_load,
  input  wire logic [4:0]        boot_wake_vhi,
  output logic [2:0]             buck4_wake_timeslot,
  output logic [1:0]             buck4_wake_regulation_mode,
  output logic [6:0]             buck4_wake_voltage_code,
  output logic [2:0]             buck4_doze_timeslot,
  output logic [1:0]             buck4_doze_regulation_mode,
  output logic [6:0]             buck4_doze_voltage_code,
  output logic                   buck4_pin_ctrl_voltage_choice,
  output logic [1:0]             buck4_pin_ctrl_source,
  output logic [2:0]             wake_slot_num,
  output logic [1:0]             wake_hw_input,
  output logic [2:0]             doze_event_slot,
  output logic                   doze_disables,
  output logic [6:0]             pin_ctrl_voltage_code,
  output logic [11:0]            wake_voltage_mv,
  output logic [11:0]            doze_voltage_mv
);

  if (ADDR_W < 17) begin : g_addr_check
    $error("ADDR_W too narrow to reach the register indices.");
  end

  // The millivolt outputs saturate above the top code; the raw code outputs, pin_ctrl_voltage_code included, pass codes above it unchanged.
  function automatic logic [11:0] code_to_mv(input logic [6:0] code);
    logic [6:0] k;
    k = (code > VCODE_SAT) ? VCODE_SAT : code;
    return 12'(VBASE_MV + VSTEP_MV * int'(k));
  endfunction : code_to_mv

  logic        wr_pend;
  logic [29:0] wr_idx;
  logic        addr_ok;
  logic        wr_fire;
  logic [15:0] next_rdata;
  logic [29:0] a_idx;
  logic        hsize_ok;
  logic        wr_size;

  assign a_idx   = 30'(haddr[ADDR_W-1:2]);
  assign addr_ok = hsel && hready && htrans == HTRANS_NONSEQ;
  assign wr_fire = wr_pend && hsize_ok;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_idx  <= 30'h0;
      wr_size <= 1'b0;
    end else begin
      wr_pend <= addr_ok && hwrite;
      wr_idx  <= a_idx;
      wr_size <= hsize == HSIZE_WORD;
    end
  end
  assign hsize_ok = wr_size;

  // Zero wait states; every transfer, mapped or not, ends OKAY.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  always_comb begin
    next_rdata = 16'h0000;
    case (a_idx)
      IDX_PIN_CTRL: begin
        next_rdata[SRC_LSB+:2]  = buck4_pin_ctrl_source;
        next_rdata[CHOICE_BIT]  = buck4_pin_ctrl_voltage_choice;
      end
      IDX_WAKE_CFG: begin
        next_rdata[SLOT_LSB+:3] = buck4_wake_timeslot;
        next_rdata[MODE_LSB+:2] = buck4_wake_regulation_mode;
        next_rdata[6:0]         = buck4_wake_voltage_code;
      end
      IDX_DOZE_CTRL: begin
        next_rdata[SLOT_LSB+:3] = buck4_doze_timeslot;
        next_rdata[MODE_LSB+:2] = buck4_doze_regulation_mode;
        next_rdata[6:0]         = buck4_doze_voltage_code;
      end
      default: begin
        next_rdata = 16'h0000;
      end
    endcase
  end

  // Reserved positions never get a source, so they read zero and writes to them vanish.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0;
    end else if (addr_ok && !hwrite) begin
      hrdata <= {16'h0000, next_rdata};
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      buck4_wake_timeslot        <= SLOT_RESET;
      buck4_wake_regulation_mode <= WAKE_MODE_RST;
    end else if (wr_fire && wr_idx == IDX_WAKE_CFG) begin
      buck4_wake_timeslot        <= hwdata[SLOT_LSB+:3];
      buck4_wake_regulation_mode <= hwdata[MODE_LSB+:2];
    end
  end

  // Boot data carries only the upper five bits; a boot load in the same cycle as a bus write wins those bits.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      buck4_wake_voltage_code <= VCODE_RESET;
    end else begin
      if (wr_fire && wr_idx == IDX_WAKE_CFG) begin
        buck4_wake_voltage_code <= hwdata[6:0];
      end
      if (boot_load) begin
        buck4_wake_voltage_code[6:VHI_LSB] <= boot_wake_vhi;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      buck4_doze_timeslot        <= SLOT_RESET;
      buck4_doze_regulation_mode <= DOZE_MODE_RST;
      buck4_doze_voltage_code    <= VCODE_RESET;
    end else if (wr_fire && wr_idx == IDX_DOZE_CTRL) begin
      buck4_doze_timeslot        <= hwdata[SLOT_LSB+:3];
      buck4_doze_regulation_mode <= hwdata[MODE_LSB+:2];
      buck4_doze_voltage_code    <= hwdata[6:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      buck4_pin_ctrl_source         <= SRC_RESET;
      buck4_pin_ctrl_voltage_choice <= 1'b0;
    end else if (wr_fire && wr_idx == IDX_PIN_CTRL) begin
      buck4_pin_ctrl_source         <= hwdata[SRC_LSB+:2];
      buck4_pin_ctrl_voltage_choice <= hwdata[CHOICE_BIT];
    end
  end

  logic       hw_owned;
  logic [2:0] next_wake_slot_num;
  logic [1:0] next_wake_hw_input;
  logic [2:0] next_doze_event_slot;
  logic       next_doze_disables;

  assign hw_owned = buck4_wake_timeslot >= SLOT_HW1;

  always_comb begin
    next_wake_slot_num = 3'h0;
    next_wake_hw_input = 2'h0;
    case (buck4_wake_timeslot)
      SLOT_HW1: next_wake_hw_input = 2'h1;
      SLOT_HW2: next_wake_hw_input = 2'h2;
      default: begin
        next_wake_slot_num = buck4_wake_timeslot;
      end
    endcase
  end

  // Disable codes count down from slot five so that power-down mirrors the power-up order.
  always_comb begin
    next_doze_event_slot = 3'h5;
    next_doze_disables   = 1'b0;
    case (buck4_doze_timeslot)
      3'h0: next_doze_event_slot = 3'h5;
      3'h6: next_doze_event_slot = 3'h3;
      3'h7: next_doze_event_slot = 3'h1;
      default: begin
        next_doze_event_slot = 3'(3'h6 - buck4_doze_timeslot);
        next_doze_disables   = !hw_owned;
      end
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wake_slot_num   <= 3'h0;
      wake_hw_input   <= 2'h0;
      doze_event_slot <= 3'h5;
      doze_disables   <= 1'b0;
    end else begin
      wake_slot_num   <= next_wake_slot_num;
      wake_hw_input   <= next_wake_hw_input;
      doze_event_slot <= next_doze_event_slot;
      doze_disables   <= next_doze_disables;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_ctrl_voltage_code <= VCODE_RESET;
      wake_voltage_mv       <= 12'(VBASE_MV);
      doze_voltage_mv       <= 12'(VBASE_MV);
    end else begin
      pin_ctrl_voltage_code <= buck4_pin_ctrl_voltage_choice ? buck4_doze_voltage_code
                                                             : buck4_wake_voltage_code;
      wake_voltage_mv       <= code_to_mv(buck4_wake_voltage_code);
      doze_voltage_mv       <= code_to_mv(buck4_doze_voltage_code);
    end
  end

  sequence s_rd_addr(logic [29:0] idx);
    addr_ok && !hwrite && a_idx == idx;
  endsequence

  sequence s_wr_wake;
    addr_ok && hwrite && hsize == HSIZE_WORD && a_idx == IDX_WAKE_CFG && !boot_load ##1 !boot_load;
  endsequence

  property p_wake_hw;
    @(posedge hclk) disable iff (!hresetn)
      ##1 (wake_hw_input == 2'h1) == ($past(buck4_wake_timeslot) == SLOT_HW1)
      && (wake_slot_num == (($past(buck4_wake_timeslot) <= SLOT_LAST) ? $past(buck4_wake_timeslot) : 3'h0));
  endproperty
  a_wake_hw: assert property (p_wake_hw) else $error("Wake slot decode wrong.");

  property p_wake_mode_rd;
    @(posedge hclk) disable iff (!hresetn)
      s_rd_addr(IDX_WAKE_CFG) |=> hrdata[MODE_LSB+:2] == $past(buck4_wake_regulation_mode);
  endproperty
  a_wake_mode_rd: assert property (p_wake_mode_rd) else $error("Wake mode readback wrong.");

  property p_wake_write;
    @(posedge hclk) disable iff (!hresetn)
      s_wr_wake |=> buck4_wake_voltage_code == $past(hwdata[6:0])
      ##1 wake_voltage_mv == code_to_mv($past(buck4_wake_voltage_code));
  endproperty
  a_wake_write: assert property (p_wake_write) else $error("Wake voltage write wrong.");

  property p_boot_vhi;
    @(posedge hclk) disable iff (!hresetn)
      boot_load |=> buck4_wake_voltage_code[6:VHI_LSB] == $past(boot_wake_vhi);
  endproperty
  a_boot_vhi: assert property (p_boot_vhi) else $error("Boot load lost upper voltage bits.");

  property p_boot_low_kept;
    @(posedge hclk) disable iff (!hresetn)
      boot_load && !(wr_fire && wr_idx == IDX_WAKE_CFG)
      |=> buck4_wake_voltage_code[1:0] == $past(buck4_wake_voltage_code[1:0]);
  endproperty
  a_boot_low_kept: assert property (p_boot_low_kept) else $error("Boot load touched low bits.");

  property p_doze_slot;
    @(posedge hclk) disable iff (!hresetn)
      $past(buck4_doze_timeslot) == 3'h2 && $stable(buck4_doze_timeslot) |-> doze_event_slot == 3'h4;
  endproperty
  a_doze_slot: assert property (p_doze_slot) else $error("Doze slot decode wrong.");

  property p_doze_hw;
    @(posedge hclk) disable iff (!hresetn)
      hw_owned && buck4_doze_timeslot inside {[3'h1:3'h5]} |=> !doze_disables;
  endproperty
  a_doze_hw: assert property (p_doze_hw) else $error("Doze disable under pin control.");

  property p_doze_mode_rd;
    @(posedge hclk) disable iff (!hresetn)
      s_rd_addr(IDX_DOZE_CTRL) |=> hrdata[MODE_LSB+:2] == $past(buck4_doze_regulation_mode);
  endproperty
  a_doze_mode_rd: assert property (p_doze_mode_rd) else $error("Doze mode readback wrong.");

  property p_doze_sat;
    @(posedge hclk) disable iff (!hresetn)
      $past(buck4_doze_voltage_code) >= VCODE_SAT |-> doze_voltage_mv == 12'hd48;
  endproperty
  a_doze_sat: assert property (p_doze_sat) else $error("Doze voltage not saturated.");

  property p_pin_choice;
    @(posedge hclk) disable iff (!hresetn)
      ##1 pin_ctrl_voltage_code == ($past(buck4_pin_ctrl_voltage_choice) ? $past(buck4_doze_voltage_code)
                                                                          : $past(buck4_wake_voltage_code));
  endproperty
  a_pin_choice: assert property (p_pin_choice) else $error("Pin control voltage choice wrong.");

  property p_src_rd;
    @(posedge hclk) disable iff (!hresetn)
      s_rd_addr(IDX_PIN_CTRL)
      |=> hrdata[12:10] == {$past(buck4_pin_ctrl_source), $past(buck4_pin_ctrl_voltage_choice)};
  endproperty
  a_src_rd: assert property (p_src_rd) else $error("Pin control readback wrong.");

  property p_reserved_zero;
    @(posedge hclk) disable iff (!hresetn)
      s_rd_addr(IDX_WAKE_CFG) or s_rd_addr(IDX_DOZE_CTRL) |=> hrdata[12:10] == 3'h0 && !hrdata[7];
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("Reserved bits read nonzero.");

endmodule : buck4_on_sleep_config_regs

// >>> sim/buck4_on_sleep_config_regs_tb.sv
`timescale 1ns/1ps
module buck4_on_sleep_config_regs_tb;
  import buck4_cfg_pkg::*;
  localparam logic [31:0] ADDR_PIN   = {IDX_PIN_CTRL, 2'b00};
  localparam logic [31:0] ADDR_WAKE  = {IDX_WAKE_CFG, 2'b00};
  localparam logic [31:0] ADDR_DOZE  = {IDX_DOZE_CTRL, 2'b00};
  localparam logic [31:0] ADDR_NONE  = 32'h0001_01a0;
  localparam int          MAX_CYCLES = 5000;

  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic        hreadyout;
  logic        hresp;
  logic [31:0] hrdata;
  logic        boot_load;
  logic [4:0]  boot_wake_vhi;
  logic [2:0]  wake_slot;
  logic [1:0]  wake_mode;
  logic [6:0]  wake_code;
  logic [2:0]  doze_slot;
  logic [1:0]  doze_mode;
  logic [6:0]  doze_code;
  logic        choice;
  logic [1:0]  source;
  logic [2:0]  wake_slot_num;
  logic [1:0]  wake_hw_input;
  logic [2:0]  doze_event_slot;
  logic        doze_disables;
  logic [6:0]  pin_code;
  logic [11:0] wake_mv;
  logic [11:0] doze_mv;
  logic [31:0] rd;
  int          n_errors;
  int          tests_run;
  int          cycles;

  buck4_on_sleep_config_regs DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .boot_load(boot_load), .boot_wake_vhi(boot_wake_vhi),
    .buck4_wake_timeslot(wake_slot), .buck4_wake_regulation_mode(wake_mode),
    .buck4_wake_voltage_code(wake_code), .buck4_doze_timeslot(doze_slot),
    .buck4_doze_regulation_mode(doze_mode), .buck4_doze_voltage_code(doze_code),
    .buck4_pin_ctrl_voltage_choice(choice), .buck4_pin_ctrl_source(source),
    .wake_slot_num(wake_slot_num), .wake_hw_input(wake_hw_input), .doze_event_slot(doze_event_slot),
    .doze_disables(doze_disables), .pin_ctrl_voltage_code(pin_code), .wake_voltage_mv(wake_mv),
    .doze_voltage_mv(doze_mv)
  );

  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end

  task automatic finish_test();
    if (n_errors == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test

  always @(posedge hclk) begin
    cycles <= cycles + 1;
    if (cycles == MAX_CYCLES) begin
      n_errors++;
      finish_test();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Only the rising edge that sees hready high ends a phase; no fixed wait-state count is assumed.
  task automatic wait_ready();
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
  endtask : wait_ready

  task automatic bus_xfer(input logic [31:0] a, input logic wr, input logic [31:0] d, input logic [2:0] sz);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    hsize  <= sz;
    wait_ready();
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wr ? d : 32'h0;
    wait_ready();
    rd = hrdata;
  endtask : bus_xfer

  task automatic wr32(input logic [31:0] a, input logic [31:0] d);
    bus_xfer(a, 1'b1, d, HSIZE_WORD);
    repeat (2) @(posedge hclk);
  endtask : wr32

  function automatic logic [11:0] mv_of(input logic [6:0] c);
    mv_of = 12'(VBASE_MV + VSTEP_MV * int'((c > VCODE_SAT) ? VCODE_SAT : c));
  endfunction : mv_of

  function automatic logic [2:0] doze_slot_of(input int c);
    case (c)
      0, 1:    doze_slot_of = 3'h5;
      6:       doze_slot_of = 3'h3;
      7:       doze_slot_of = 3'h1;
      default: doze_slot_of = 3'(6 - c);
    endcase
  endfunction : doze_slot_of

  initial begin
    logic [6:0] codes[5];
    codes = '{7'h00, 7'h01, 7'h65, 7'h66, 7'h7f};
    {hresetn, hsel, haddr, htrans, hwrite, hsize, hwdata, boot_load, boot_wake_vhi} = '0;
    {n_errors, tests_run, cycles} = '0;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    bus_xfer(ADDR_WAKE, 1'b0, 32'h0, HSIZE_WORD);
    check(rd, 32'h0000_0100);
    bus_xfer(ADDR_DOZE, 1'b0, 32'h0, HSIZE_WORD);
    check(rd, 32'h0000_0300);
    check(32'(doze_event_slot), 32'h5);
    check(32'(wake_mv), 32'(VBASE_MV));
    // Reserved bits must drop even when every bit is written as one.
    wr32(ADDR_WAKE, 32'hffff_ffff);
    bus_xfer(ADDR_WAKE, 1'b0, 32'h0, HSIZE_WORD);
    check(rd, 32'h0000_e37f);
    wr32(ADDR_DOZE, 32'hffff_ffff);
    bus_xfer(ADDR_DOZE, 1'b0, 32'h0, HSIZE_WORD);
    check(rd, 32'h0000_e37f);
    // Only reserved and upper bits set, so every stored field must come back zero.
    wr32(ADDR_WAKE, 32'hffff_1c80);
    bus_xfer(ADDR_WAKE, 1'b0, 32'h0, HSIZE_WORD);
    check(rd, 32'h0000_0000);
    wr32(ADDR_NONE, 32'hffff_ffff);
    check(32'(hresp), 32'h0);
    bus_xfer(ADDR_NONE, 1'b0, 32'h0, HSIZE_WORD);
    check(rd, 32'h0);
    for (int i = 0; i < 8; i++) begin
      wr32(ADDR_WAKE, 32'((i << 13) | ((i % 4) << 8)));
      check(32'(wake_slot), 32'(i));
      check(32'(wake_slot_num), (i >= 1 && i <= 5) ? 32'(i) : 32'h0);
      check(32'(wake_hw_input), (i == 6) ? 32'h1 : (i == 7) ? 32'h2 : 32'h0);
      check(32'(wake_mode), 32'(i % 4));
    end
    // Both enable-input owners are visited, not only the first.
    for (int w = 0; w < 8; w = (w == 0) ? 6 : w + 1) begin
      wr32(ADDR_WAKE, 32'(w << 13));
      for (int i = 0; i < 8; i++) begin
        wr32(ADDR_DOZE, 32'((i << 13) | ((i % 4) << 8)));
        check(32'(doze_slot), 32'(i));
        check(32'(doze_event_slot), 32'(doze_slot_of(i)));
        check(32'(doze_disables), 32'(w == 0 && i >= 1 && i <= 5));
        check(32'(doze_mode), 32'(i % 4));
      end
    end
    foreach (codes[k]) begin
      wr32(ADDR_WAKE, 32'(codes[k]));
      wr32(ADDR_DOZE, 32'(codes[k]));
      check(32'(doze_code), 32'(codes[k]));
      check(32'(wake_mv), 32'(mv_of(codes[k])));
      check(32'(doze_mv), 32'(mv_of(codes[k])));
    end
    wr32(ADDR_WAKE, 32'h05);
    wr32(ADDR_DOZE, 32'h40);
    wr32(ADDR_PIN, 32'hffff_ffff);
    bus_xfer(ADDR_PIN, 1'b0, 32'h0, HSIZE_WORD);
    check(rd, 32'h0000_1c00);
    for (int s = 0; s < 4; s++) begin
      wr32(ADDR_PIN, 32'((s << 11) | ((s % 2) << 10)));
      check(32'(source), 32'(s));
      check(32'(choice), 32'(s % 2));
      check(32'(pin_code), (s % 2 == 1) ? 32'h40 : 32'h05);
    end
    // Boot data carries only the upper five bits, so the low pair written earlier must survive.
    @(posedge hclk);
    boot_load     <= 1'b1;
    boot_wake_vhi <= 5'h15;
    @(posedge hclk);
    boot_load <= 1'b0;
    repeat (2) @(posedge hclk);
    check(32'(wake_code), 32'h55);
    check(32'(wake_mv), 32'(mv_of(7'h55)));
    bus_xfer(ADDR_WAKE, 1'b0, 32'h0, HSIZE_WORD);
    check(rd, 32'h0000_0055);
    finish_test();
  end
endmodule : buck4_on_sleep_config_regs_tb
